//--- core/rand_gen.sv
`timescale 1ns/10ps
`include "sch_map.svh"
module rand_gen (
   input  wire logic        sys_clk,
   input  wire logic        rst,
   output logic [31:0]      value
);
   import sch_pkg::*;

   logic [31:0] value_q;
   logic [31:0] value_d;

   // galois lfsr, steps every cycle so successive draws differ
   always_comb begin
      value_d = value_q >> 1;
      if (value_q[0]) begin
         value_d = (value_q >> 1) ^ `LFSR_TAPS;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         value_q <= `LFSR_SEED;
      end else begin
         value_q <= value_d;
      end
   end

   assign value = value_q;
endmodule // rand_gen

//--- core/sch_map.svh
`ifndef SCH_MAP_SVH
`define SCH_MAP_SVH

// ***********************************************************
// frame header fields
// ***********************************************************
`define CMD_TYPE     8'hC0
`define TYPE_IGNORE  8'h10
`define PERSIST_BIT  4
`define GRP_SYS      8'h02
`define ID_VER       8'h06
`define ID_RND       8'h08
`define ID_WR        8'h0B
`define ID_RD        8'h0C
`define ID_ADDR      8'h0D
`define HDR_BYTES    8'h04
`define RSP_FIXED    8'h06

// ***********************************************************
// payload lengths and limits
// ***********************************************************
`define LEN_VER      8'h0D
`define LEN_RND      8'h0B
`define LEN_ACK      8'h02
`define RND_CNT      8'h08
`define AREA_LAST    17'h000FF
`define MAX_CNT      8'h20
`define WR_OVERHEAD  8'h03
`define RD_LEN       8'h03
`define ADDR_LEN     8'h07
`define ADDR_RANDOM  8'h01
`define PAY_DEPTH    8'd35
`define AREA_BYTES   255
`define VER_BYTES    8'd11

// ***********************************************************
// result codes, text sizing, random source
// ***********************************************************
`define RES_OK       16'h0000
`define RES_BAD      16'h0101
`define RES_UNK      16'h0102
`define TXT_RD_BASE  7'h0D
`define LFSR_SEED    32'h5A3C_96E1
`define LFSR_TAPS    32'h8020_0003

`endif

//--- core/sch_pkg.sv
package sch_pkg;
`include "sch_map.svh"

   typedef enum logic [3:0] {
      S_HDR  = 4'b0001,
      S_PAY  = 4'b0010,
      S_EXEC = 4'b0100,
      S_RSP  = 4'b1000
   } state_t;

   typedef struct packed {
      logic [7:0]  hw;
      logic [15:0] proto;
      logic [31:0] stack;
      logic [31:0] app;
   } version_t;

   typedef struct packed {
      state_t                         state;
      logic [3:0][7:0]                hdr;
      logic [7:0]                     idx;
      logic [`PAY_DEPTH-1:0][7:0]     pay;
      logic [15:0]                    result;
      logic [7:0]                     rlen;
      logic                           rx_ready;
      logic                           tx_valid;
      logic [7:0]                     tx_data;
      logic [47:0]                    addr;
      logic                           atype;
      logic [47:0]                    fac;
      logic                           fac_taken;
      logic [47:0]                    nv_addr;
      logic                           nv_type;
      logic                           nv_valid;
      logic [6:0]                     text_len;
   } st_t;

endpackage

//--- core/system_command_handler.sv
// Contract
// RQ1 - version query id 06, empty payload; answer same type/group/id, length 0D
// RQ2 - version answer: app32, stack32, protocol16, hardware8, same as boot event
// RQ3 - random query id 08; answer length 0B: count byte 08 plus eight bytes
// RQ4 - 255-byte user area; a write stores 1 to 32 bytes anywhere
// RQ5 - host keeps offset plus count within 255 for writes and reads
// RQ6 - user write id 0B, payload 4 to 35; answer payload length 02
// RQ7 - write payload: 16-bit offset, then count byte, then data bytes
// RQ8 - never-written user bytes read back as zero
// RQ9 - user read id 0C, payload 3: 16-bit offset and count 1 to 32
// RQ10 - read answer: payload 4 to 35, count byte then data
// RQ11 - text form of the read answer is 15 to 77 characters
// RQ12 - address set id 0D, payload 7: six address bytes big-endian, type
// RQ13 - all-zero address restores the factory address
// RQ14 - host clears top bits for public, sets them for static random
// RQ15 - new address volatile unless header bit 4 or text suffix asks
// RQ16 - setting the address leaves the stored device name untouched
// RQ17 - host restarts advertising so a new address takes effect
// RQ18 - default address is fixed public, derived from the random source
// RQ19 - out-of-range arguments get an error answer, storage unchanged
`timescale 1ns/10ps
`include "sch_map.svh"
module system_command_handler (
   input  wire logic            sys_clk,
   input  wire logic            rst,
   input  wire logic            por,
   input  wire logic            rx_valid,
   input  wire logic [7:0]      rx_data,
   output logic                 rx_ready,
   output logic                 tx_valid,
   output logic [7:0]           tx_data,
   input  wire logic            tx_ready,
   input  wire logic            text_persist,
   input  sch_pkg::version_t    version,
   output logic [47:0]          dev_addr,
   output logic                 dev_addr_type,
   output logic [6:0]           text_len
);
   import sch_pkg::*;
   localparam st_t ST_RESET = '{state: S_HDR, rx_ready: 1'b1, default: '0};
   st_t         q;
   st_t         d;
   logic [31:0] rng;
   logic [7:0]  mem [0:`AREA_BYTES-1];
   logic [15:0] arg_off;
   logic [7:0]  arg_cnt;
   logic [47:0] arg_addr;
   logic [7:0]  rd_addr;
   logic [7:0]  rsp_byte;
   logic        range_ok, wr_ok, rd_ok, addr_ok, addr_zero;
   logic        persist, hdr_ok, wr_go, ld, exec_ok;
   rand_gen u_rand (
      .sys_clk (sys_clk),
      .rst     (rst | por),
      .value   (rng)
   );
   // ***********************************************************
   // argument decode
   // ***********************************************************
   assign arg_off  = {q.pay[1], q.pay[0]};
   assign arg_cnt  = q.pay[2];
   assign arg_addr = {q.pay[0], q.pay[1], q.pay[2],
                      q.pay[3], q.pay[4], q.pay[5]};                // RQ12
   assign range_ok = (arg_cnt != 8'h00) && (arg_cnt <= `MAX_CNT) &&
                     ((17'(arg_off) + 17'(arg_cnt)) <= `AREA_LAST);
   assign wr_ok    = range_ok &&
                     (9'(q.hdr[1]) == 9'(arg_cnt) + 9'(`WR_OVERHEAD)); // RQ7
   assign rd_ok    = range_ok && (q.hdr[1] == `RD_LEN);             // RQ9
   assign addr_ok  = (q.hdr[1] == `ADDR_LEN) &&
                     (q.pay[6] <= `ADDR_RANDOM);                    // RQ19
   assign addr_zero = (arg_addr == 48'h0);
   assign persist  = q.hdr[0][`PERSIST_BIT] | text_persist;        // RQ15
   assign hdr_ok   = ((q.hdr[0] & ~`TYPE_IGNORE) == `CMD_TYPE) &&
                     (q.hdr[2] == `GRP_SYS);
   assign rd_addr  = arg_off[7:0] + q.idx - (`RSP_FIXED + 8'h01);
   assign ld       = (q.state == S_RSP) && (!q.tx_valid || tx_ready) &&
                     (9'(q.idx) < 9'(q.rlen) + 9'(`HDR_BYTES));
   // ***********************************************************
   // response byte at the current index
   // ***********************************************************
   always_comb begin
      rsp_byte = 8'h00;
      case (q.idx)
         8'h00: rsp_byte = `CMD_TYPE;                               // RQ1
         8'h01: rsp_byte = q.rlen;
         8'h02: rsp_byte = `GRP_SYS;
         8'h03: rsp_byte = q.hdr[3];
         8'h04: rsp_byte = q.result[7:0];
         8'h05: rsp_byte = q.result[15:8];
         default: begin
            case (q.hdr[3])
               `ID_VER: begin
                  if (q.idx - `RSP_FIXED < `VER_BYTES) begin
                     rsp_byte = version[(q.idx - `RSP_FIXED) * 8 +: 8]; // RQ2
                  end
               end
               `ID_RND: begin
                  rsp_byte = (q.idx == `RSP_FIXED) ? `RND_CNT
                                                   : rng[7:0];      // RQ3
               end
               `ID_RD: begin
                  rsp_byte = (q.idx == `RSP_FIXED) ? arg_cnt
                                                   : mem[rd_addr];  // RQ10
               end
               default: rsp_byte = 8'h00;
            endcase
         end
      endcase
   end
   // ***********************************************************
   // command sequencer
   // ***********************************************************
   always_comb begin
      d     = q;
      wr_go = 1'b0;
      if (!q.fac_taken) begin
         // fixed public default taken from the seeded random source
         d.fac       = {2'b00, rng[13:0], rng};                     // RQ18
         d.fac_taken = 1'b1;
         d.addr      = q.nv_valid ? q.nv_addr : {2'b00, rng[13:0], rng};
         d.atype     = q.nv_valid ? q.nv_type : 1'b0;               // RQ15
      end
      case (q.state)
         S_HDR: begin
            if (rx_valid && q.rx_ready) begin
               d.hdr[q.idx[1:0]] = rx_data;
               d.idx = q.idx + 8'h01;
               if (q.idx == `HDR_BYTES - 8'h01) begin
                  d.idx = 8'h00;
                  if (q.hdr[1] == 8'h00) begin
                     d.state    = S_EXEC;
                     d.rx_ready = 1'b0;
                  end else begin
                     d.state = S_PAY;
                  end
               end
            end
         end
         S_PAY: begin
            if (rx_valid && q.rx_ready) begin
               if (q.idx < `PAY_DEPTH) begin
                  d.pay[q.idx] = rx_data;
               end
               d.idx = q.idx + 8'h01;
               if (q.idx + 8'h01 == q.hdr[1]) begin
                  d.idx      = 8'h00;
                  d.state    = S_EXEC;
                  d.rx_ready = 1'b0;
               end
            end
         end
         S_EXEC: begin
            d.state  = S_RSP;
            d.idx    = 8'h00;
            d.result = `RES_BAD;
            d.rlen   = `LEN_ACK;
            case (q.hdr[3])
               `ID_VER: begin
                  if (q.hdr[1] == 8'h00) begin
                     d.result = `RES_OK;
                     d.rlen   = `LEN_VER;                           // RQ1
                  end
               end
               `ID_RND: begin
                  if (q.hdr[1] == 8'h00) begin
                     d.result = `RES_OK;
                     d.rlen   = `LEN_RND;                           // RQ3
                  end
               end
               `ID_WR: begin
                  if (wr_ok) begin
                     d.result = `RES_OK;                            // RQ6
                     wr_go    = 1'b1;                               // RQ4
                  end
               end
               `ID_RD: begin
                  if (rd_ok) begin
                     d.result   = `RES_OK;
                     d.rlen     = arg_cnt + `WR_OVERHEAD;          // RQ10
                     d.text_len = `TXT_RD_BASE +
                                  7'({arg_cnt[5:0], 1'b0});         // RQ11
                  end
               end
               `ID_ADDR: begin
                  if (addr_ok) begin
                     // only the address moves; the device name is not here
                     d.result = `RES_OK;                            // RQ16
                     d.addr   = addr_zero ? q.fac : arg_addr;       // RQ13
                     d.atype  = addr_zero ? 1'b0 : q.pay[6][0];
                     if (persist) begin
                        d.nv_addr  = arg_addr;                      // RQ15
                        d.nv_type  = q.pay[6][0];
                        d.nv_valid = !addr_zero;
                     end
                  end
               end
               default: d.result = `RES_UNK;
            endcase
            if (!hdr_ok) begin
               // frames of other groups are not ours: drop silently
               d          = q;
               d.state    = S_HDR;
               d.rx_ready = 1'b1;
               wr_go      = 1'b0;
            end
         end
         S_RSP: begin
            if (!q.tx_valid || tx_ready) begin
               if (ld) begin
                  d.tx_valid = 1'b1;
                  d.tx_data  = rsp_byte;
                  d.idx      = q.idx + 8'h01;
               end else begin
                  d.tx_valid = 1'b0;
                  d.idx      = 8'h00;
                  d.state    = S_HDR;
                  d.rx_ready = 1'b1;
               end
            end
         end
         default: d = ST_RESET;
      endcase
   end
   always_ff @(posedge sys_clk) begin
      if (por) begin
         q <= ST_RESET;
      end else if (rst) begin
         q          <= ST_RESET;
         q.nv_addr  <= q.nv_addr;
         q.nv_type  <= q.nv_type;
         q.nv_valid <= q.nv_valid;
      end else begin
         q <= d;
      end
   end
   // ***********************************************************
   // user area, kept over rst, blank after por
   // ***********************************************************
   for (genvar k = 0; k < `AREA_BYTES; k++) begin : g_area
      always_ff @(posedge sys_clk) begin
         if (por) begin
            mem[k] <= 8'h00;                                     // RQ8
         end else if (wr_go && (k >= 32'(arg_off[7:0])) &&
                      (k < 32'(arg_off[7:0]) + 32'(arg_cnt))) begin
            mem[k] <= q.pay[k - 32'(arg_off[7:0]) + 3];          // RQ4
         end
      end
   end
   assign rx_ready      = q.rx_ready;
   assign tx_valid      = q.tx_valid;
   assign tx_data       = q.tx_data;
   assign dev_addr      = q.addr;
   assign dev_addr_type = q.atype;
   assign text_len      = q.text_len;
   // ***********************************************************
   // assertions
   // ***********************************************************
   assign exec_ok = (q.state == S_EXEC) && hdr_ok;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst | por);
   a_ver_length: assert property (exec_ok && q.hdr[3] == `ID_VER && // RQ1
      q.hdr[1] == 8'h00 |=> q.rlen == 8'h0D && q.state == S_RSP)
      else $error("version answer length wrong");
   a_ver_first: assert property (ld && q.idx == 8'h06 &&          // RQ2
      q.hdr[3] == `ID_VER && q.result == `RES_OK
      |=> tx_valid && tx_data == version.app[7:0])
      else $error("version app byte wrong");
   a_rnd_count: assert property (ld && q.idx == 8'h06 &&          // RQ3
      q.hdr[3] == `ID_RND && q.result == `RES_OK
      |=> tx_data == 8'h08 && q.rlen == 8'h0B)
      else $error("random count byte wrong");
   a_wr_store: assert property (wr_go                              // RQ4
      |=> mem[$past(arg_off[7:0])] == $past(q.pay[3]))
      else $error("user write not stored");
   a_wr_ack: assert property (exec_ok && q.hdr[3] == `ID_WR &&    // RQ6
      wr_ok |=> q.rlen == 8'h02 && q.result == 16'h0000)
      else $error("write ack wrong");
   a_rd_length: assert property (exec_ok && q.hdr[3] == `ID_RD && // RQ10
      rd_ok |=> q.rlen == $past(arg_cnt) + 8'h03)
      else $error("read answer length wrong");
   a_text_size: assert property (exec_ok && q.hdr[3] == `ID_RD && // RQ11
      rd_ok |=> text_len >= 7'h0F && text_len <= 7'h4D)
      else $error("text read length out of range");
   a_bad_reject: assert property (exec_ok && q.hdr[3] == `ID_WR && // RQ19
      !wr_ok |-> !wr_go ##1 q.result == 16'h0101 && q.rlen == 8'h02)
      else $error("bad write not rejected");
   a_addr_zero: assert property (exec_ok && q.hdr[3] == `ID_ADDR && // RQ13
      addr_ok && addr_zero |=> dev_addr == q.fac && !dev_addr_type)
      else $error("factory address not restored");
   a_addr_keep: assert property (exec_ok && q.hdr[3] == `ID_ADDR && // RQ15
      addr_ok && !persist |=> $stable(q.nv_addr) && $stable(q.nv_valid))
      else $error("volatile address was stored");
   a_fac_public: assert property (q.fac[47:46] == 2'b00)       // RQ18
      else $error("factory address not public");
   c_ver: cover property (exec_ok && q.hdr[3] == `ID_VER);
   c_read: cover property (exec_ok && q.hdr[3] == `ID_RD && rd_ok);
   c_persist: cover property (exec_ok && q.hdr[3] == `ID_ADDR &&
      addr_ok && persist);
endmodule // system_command_handler

//--- dv/host_model.sv
`timescale 1ns/10ps
module host_model (
   input  wire logic       sys_clk,
   input  wire logic       rx_ready,
   input  wire logic       tx_valid,
   input  wire logic [7:0] tx_data,
   input  wire logic       slow,
   output logic            rx_valid,
   output logic [7:0]      rx_data,
   output logic            tx_ready,
   output logic            got,
   output logic [7:0]      got_byte
);
   initial begin
      rx_valid = 1'b0;
      rx_data  = 8'h00;
      tx_ready = 1'b1;
      got      = 1'b0;
      got_byte = 8'h00;
   end

   // *****
   // each byte held until the edge that takes it
   // *****
   task automatic send_frame(input logic [7:0] b[$], output bit ok);
      int n;
      ok = 1'b1;
      foreach (b[i]) begin
         @(negedge sys_clk);
         rx_valid = 1'b1;
         rx_data  = b[i];
         n = 0;
         do begin
            @(posedge sys_clk);
            n++;
         end while (!rx_ready && n < 400);
         if (n >= 400) ok = 1'b0;
      end
      @(negedge sys_clk);
      rx_valid = 1'b0;
      rx_data  = ~rx_data;
   endtask

   // a slow host stalls response bytes at random
   always @(negedge sys_clk) tx_ready <= slow ? 1'($urandom_range(1)) : 1'b1;

   always @(posedge sys_clk) begin
      got      <= tx_valid && tx_ready;
      got_byte <= tx_data;
   end
endmodule // host_model

//--- dv/system_command_handler_tb_top.sv
`timescale 1ns/10ps
`include "sch_map.svh"
module system_command_handler_tb_top;
   import sch_pkg::*;
   localparam logic [31:0] lfsr_init = `LFSR_SEED;
   logic        sys_clk, rst, por, rx_valid, rx_ready, tx_valid, tx_ready;
   logic        text_persist, dev_addr_type, got, slow;
   logic [7:0]  rx_data, tx_data, got_byte;
   logic [6:0]  text_len;
   logic [47:0] dev_addr, fac, a;
   version_t    ver;
   logic [7:0]  mem [255];
   logic [8:0]  exp_q [$];
   logic [8:0]  d [$];
   logic [8:0]  none [$];
   logic [7:0]  nil [$];
   int          err_count, total_checks, c;
   bit          ok;

   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   system_command_handler system_command_handler_inst (
      .sys_clk(sys_clk), .rst(rst), .por(por), .rx_valid(rx_valid),
      .rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid),
      .tx_data(tx_data), .tx_ready(tx_ready), .text_persist(text_persist),
      .version(ver), .dev_addr(dev_addr), .dev_addr_type(dev_addr_type),
      .text_len(text_len));

   host_model host_model_inst (
      .sys_clk(sys_clk), .rx_ready(rx_ready), .tx_valid(tx_valid),
      .tx_data(tx_data), .slow(slow), .rx_valid(rx_valid),
      .rx_data(rx_data), .tx_ready(tx_ready), .got(got),
      .got_byte(got_byte));

   // *****
   // shared tasks
   // *****
   task automatic check(input logic [47:0] seen, input logic [47:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish();
      if (err_count == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // bit 8 of a note marks a byte whose value is known
   always @(posedge sys_clk) begin
      if (got) begin
         if (exp_q.size() == 0) check(48'(got_byte), 48'h100);
         else begin
            c = exp_q.pop_front();
            if (c[8]) check(48'(got_byte), 48'(c[7:0]));
         end
      end
   end

   task automatic rsp(input logic [7:0] id, input logic [15:0] res,
                      input logic [8:0] p[$]);
      exp_q.push_back({1'b1, `CMD_TYPE});
      exp_q.push_back({1'b1, 8'(p.size() + 2)});
      exp_q.push_back({1'b1, `GRP_SYS});
      exp_q.push_back({1'b1, id});
      exp_q.push_back({1'b1, res[7:0]});
      exp_q.push_back({1'b1, res[15:8]});
      foreach (p[i]) exp_q.push_back(p[i]);
   endtask

   task automatic cmd(input logic [7:0] ty, id, input logic [7:0] p[$]);
      logic [7:0] f[$];
      int n;
      f = {ty, 8'(p.size()), `GRP_SYS, id};
      f = {f, p};
      host_model_inst.send_frame(f, ok);
      n = 0;
      while ((exp_q.size() != 0 || !rx_ready) && n < 3000) begin
         @(posedge sys_clk);
         n++;
      end
      if (!ok || n >= 3000) begin
         err_count++;
         tally_and_finish();
      end
      @(negedge sys_clk);
   endtask

   task automatic wr(input int off, input int cnt);
      logic [7:0] p[$];
      bit good;
      good = cnt >= 1 && cnt <= 32 && off + cnt <= 255;
      p = {8'(off), 8'(off >> 8), 8'(cnt)};
      repeat (cnt) p.push_back(8'($urandom));
      if (good) for (int i = 0; i < cnt; i++) mem[off + i] = p[3 + i];
      rsp(`ID_WR, good ? `RES_OK : `RES_BAD, none);
      cmd(`CMD_TYPE, `ID_WR, p);
   endtask

   task automatic rd(input int off, input int cnt);
      logic [8:0] q[$];
      bit good;
      good = cnt >= 1 && cnt <= 32 && off + cnt <= 255;
      if (good) begin
         q.push_back({1'b1, 8'(cnt)});
         for (int i = 0; i < cnt; i++) q.push_back({1'b1, mem[off + i]});
      end
      rsp(`ID_RD, good ? `RES_OK : `RES_BAD, q);
      cmd(`CMD_TYPE, `ID_RD, {8'(off), 8'(off >> 8), 8'(cnt)});
      if (good) check(48'(text_len), 48'(13 + 2 * cnt));
   endtask

   task automatic setaddr(input logic [47:0] v, input logic [7:0] t,
                          input bit hdr, input bit txt);
      logic [7:0] p[$];
      for (int i = 5; i >= 0; i--) p.push_back(v[8*i +: 8]);
      p.push_back(t);
      text_persist = txt;
      rsp(`ID_ADDR, t <= 1 ? `RES_OK : `RES_BAD, none);
      cmd(hdr ? (`CMD_TYPE | `TYPE_IGNORE) : `CMD_TYPE, `ID_ADDR, p);
      text_persist = 1'b0;
   endtask

   task automatic reboot(input bit full);
      rst = 1'b1;
      por = full;
      repeat (2) @(negedge sys_clk);
      rst = 1'b0;
      por = 1'b0;
      repeat (2) @(negedge sys_clk);
      if (full) foreach (mem[i]) mem[i] = 8'h00;
   endtask

   // *****
   // main sequence
   // *****
   initial begin
      rst = 1'b1;
      por = 1'b1;
      slow = 1'b0;
      text_persist = 1'b0;
      err_count = 0;
      total_checks = 0;
      void'($urandom(32'h5F6A9537));
      ver = 88'({$urandom, $urandom, $urandom});
      fac = {2'b00, lfsr_init[13:0], lfsr_init};
      foreach (mem[i]) mem[i] = 8'h00;
      repeat (12) @(negedge sys_clk);
      rst = 1'b0;
      por = 1'b0;
      repeat (2) @(negedge sys_clk);
      check(dev_addr, fac);
      check(48'(dev_addr_type), 48'h0);
      d = {};
      for (int i = 0; i < 11; i++) d.push_back({1'b1, ver[8*i +: 8]});
      rsp(`ID_VER, `RES_OK, d);
      cmd(`CMD_TYPE, `ID_VER, nil);
      repeat (2) begin
         d = {{1'b1, `RND_CNT}};
         repeat (8) d.push_back(9'h000);
         rsp(`ID_RND, `RES_OK, d);
         cmd(`CMD_TYPE, `ID_RND, nil);
      end
      rd(223, 32);
      wr(223, 32);
      wr(254, 1);
      slow = 1'b1;
      repeat (6) begin
         c = $urandom_range(32, 1);
         wr($urandom_range(255 - c), c);
      end
      wr(224, 32);
      wr(0, 33);
      wr(0, 0);
      rd(0, 0);
      rd(0, 33);
      rd(250, 6);
      rsp(8'h01, `RES_UNK, none);
      cmd(`CMD_TYPE, 8'h01, nil);
      // foreign frame type: no answer may come back
      cmd(8'hC1, `ID_VER, nil);
      for (int o = 0; o < 224; o += 32) rd(o, 32);
      rd(224, 31);
      reboot(1'b0);
      rd(223, 32);
      reboot(1'b1);
      rd(223, 32);
      a = {2'b11, 46'({$urandom, $urandom})};
      setaddr(a, 8'h01, 1'b0, 1'b0);
      check(dev_addr, a);
      check(48'(dev_addr_type), 48'h1);
      reboot(1'b0);
      check(dev_addr, fac);
      a = {2'b00, 46'({$urandom, $urandom})};
      setaddr(a, 8'h00, 1'b1, 1'b0);
      reboot(1'b0);
      check(dev_addr, a);
      check(48'(dev_addr_type), 48'h0);
      a = {2'b11, 46'({$urandom, $urandom})};
      // no advertising traffic runs around the change
      setaddr(a, 8'h01, 1'b0, 1'b1);
      reboot(1'b0);
      check(dev_addr, a);
      setaddr(48'h0, 8'h02, 1'b1, 1'b0);
      check(dev_addr, a);
      setaddr(48'h0, 8'h00, 1'b1, 1'b0);
      check(dev_addr, fac);
      reboot(1'b0);
      check(dev_addr, fac);
      tally_and_finish();
   end
endmodule // system_command_handler_tb_top
